// ==== rtl/status_readout_pkg.sv ====
// register map, field layout and shared types of the status readout bank
package status_readout_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_FEATURE_FLAGS = 8'h1C;
   localparam logic [7:0] ADDR_DATA_FLAGS    = 8'h1D;
   localparam logic [7:0] ADDR_STEP_BYTE0    = 8'h1E;
   localparam logic [7:0] ADDR_STEP_BYTE1    = 8'h1F;
   localparam logic [7:0] ADDR_STEP_BYTE2    = 8'h20;
   localparam logic [7:0] ADDR_STEP_BYTE3    = 8'h21;
   localparam logic [7:0] ADDR_DIE_TEMP      = 8'h22;
   localparam logic [7:0] ADDR_FILL_LOW      = 8'h24;
   localparam logic [7:0] ADDR_FILL_HIGH     = 8'h25;
   localparam logic [7:0] ADDR_QUEUE_PORT    = 8'h26;
   localparam logic [7:0] ADDR_MOTION_CLASS  = 8'h27;
   localparam logic [7:0] ADDR_WMARK_LOW     = 8'h30;
   localparam logic [7:0] ADDR_WMARK_HIGH    = 8'h31;

   // feature event flag positions
   localparam int FEAT_ERROR_BIT    = 7;
   localparam int FEAT_MOTION_BIT   = 6;
   localparam int FEAT_WAKEUP_BIT   = 5;
   localparam int FEAT_TILT_BIT     = 3;
   localparam int FEAT_ACTIVITY_BIT = 2;
   localparam int FEAT_STEP_BIT     = 1;

   // data and queue event flag positions
   localparam int DATA_ACC_RDY_BIT  = 7;
   localparam int DATA_AUX_RDY_BIT  = 5;
   localparam int DATA_QUEUE_WM_BIT = 1;
   localparam int DATA_QUEUE_FULL_BIT = 0;

   // widths of the value fields
   localparam int STEP_W      = 32;
   localparam int FILL_W      = 14;
   localparam int FILL_HIGH_W = 6;
   localparam int CLASS_W     = 2;

   // reset values, and the bytes read at unmapped addresses and from an empty queue
   localparam logic [7:0]        FLAGS_RESET = 8'h00;
   localparam logic [7:0]        BYTE_RESET  = 8'h00;
   localparam logic [FILL_W-1:0] WMARK_RESET = 14'h0000;
   localparam logic [7:0]        UNMAPPED_RD = 8'h00;
   localparam logic [7:0]        EMPTY_RD    = 8'h00;

   // queue depth in bytes
   localparam int QUEUE_DEPTH = 1024;

   // pedometer activity classification
   typedef enum logic [1:0] {
      CLASS_STILL   = 2'h0,
      CLASS_WALKING = 2'h1,
      CLASS_RUNNING = 2'h2,
      CLASS_UNKNOWN = 2'h3
   } motion_class_t;

   // one request from the register port
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // one-cycle event pulses from the feature engines
   typedef struct packed {
      logic error;
      logic any_no_motion;
      logic wakeup;
      logic wrist_tilt;
      logic step;
   } feature_events_t;

   // one-cycle data ready pulses
   typedef struct packed {
      logic acc_ready;
      logic aux_ready;
   } data_events_t;

endpackage

// ==== rtl/byte_queue.sv ====
// byte-wide first-in first-out queue with an occupancy counter
`timescale 1ns/1ps
`default_nettype none
module byte_queue #(
   parameter int DEPTH  = 1024,
   parameter int DATA_W = 8,
   parameter int CNT_W  = 14
) (
   // clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   // fill side
   input  wire logic              wr_valid,
   output logic                   wr_ready,
   input  wire logic [DATA_W-1:0] wr_data,
   // drain side
   input  wire logic              rd_en,
   output logic [DATA_W-1:0]      rd_data,
   // occupancy
   output logic [CNT_W-1:0]       count,
   output logic                   full,
   output logic                   empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
   localparam logic [AW-1:0]    LAST_C  = AW'(DEPTH - 1);

   logic [DATA_W-1:0] mem [DEPTH];
   logic [AW-1:0]     wr_ptr_q;
   logic [AW-1:0]     rd_ptr_q;
   logic [CNT_W-1:0]  count_q;
   logic              push;
   logic              pop;

   // handshakes; a full queue stalls the producer
   assign full     = (count_q == DEPTH_C);
   assign empty    = (count_q == '0);
   assign wr_ready = ~full;
   assign push     = wr_valid & ~full;
   assign pop      = rd_en & ~empty;
   assign count    = count_q;
   assign rd_data  = mem[rd_ptr_q]; // oldest byte, sampled by the reader

   // storage has no reset; contents are only read behind the count
   always_ff @(posedge clk) begin
      if (clk_en && push) begin
         mem[wr_ptr_q] <= wr_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + AW'(1);
         end
      end
   end

   // occupancy follows both sides in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= '0;
      end else if (clk_en) begin
         unique case ({push, pop})
            2'b10:   count_q <= count_q + CNT_W'(1);
            2'b01:   count_q <= count_q - CNT_W'(1);
            default: count_q <= count_q;
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== rtl/status_readout_register_bank.sv ====
// status and result register bank of the motion sensor
//
// Notes on behaviour
// [R1] reading feature flags clears them all
// [R2] feature flag bit placement, bits 4,0 zero
// [R3] reading data/queue flags clears them all
// [R4] data/queue flag placement, other bits zero
// [R5] step count over four bytes, LSB first
// [R6] temperature byte, two's complement, 23 C at zero
// [R7] queue fill count tracks writes and drains
// [R8] fill count split 8 low, 6 high bits
// [R9] queue drained through one byte port
// [R10] each port read pops the oldest byte
// [R11] activity class in bits 1:0, rest zero
// [R12] class codes still, walking, running, unknown
`timescale 1ns/1ps
`default_nettype none
module status_readout_register_bank
   import status_readout_pkg::*;
#(
   parameter int DEPTH = status_readout_pkg::QUEUE_DEPTH
) (
   // clock, reset, enable
   input  wire logic                               clk,
   input  wire logic                               rst,
   input  wire logic                               clk_en,
   // register port
   input  wire status_readout_pkg::reg_req_t       reg_req,
   output logic [7:0]                              reg_rdata,
   // feature engine results
   input  wire status_readout_pkg::feature_events_t feat_events,
   input  wire status_readout_pkg::data_events_t   data_events,
   input  wire logic [status_readout_pkg::STEP_W-1:0] step_count,
   input  wire logic signed [7:0]                  die_temp,
   input  wire status_readout_pkg::motion_class_t  motion_class,
   // queue fill side
   input  wire logic                               queue_wr_valid,
   output logic                                    queue_wr_ready,
   input  wire logic [7:0]                         queue_wr_data,
   // queue level indications
   output logic                                    queue_full,
   output logic                                    queue_wmark
);
   import status_readout_pkg::*;

   // decoded strobes
   logic rd_feat;
   logic rd_data;
   logic rd_step0;
   logic rd_fill_low;
   logic rd_port;
   logic wr_wm_low;
   logic wr_wm_high;

   // flag state
   logic [7:0] feat_flags_q;
   logic [7:0] feat_flags_d;
   logic [7:0] feat_set;
   logic [7:0] data_flags_q;
   logic [7:0] data_flags_d;
   logic [7:0] data_set;

   // sampled results
   logic [STEP_W-1:0]   step_q;
   logic [STEP_W-1:0]   step_hold_q;
   logic signed [7:0]   temp_q;
   motion_class_t       class_q;
   logic                class_seen_q;
   logic                class_change;

   // queue and level tracking
   logic [FILL_W-1:0]      fill;
   logic [FILL_HIGH_W-1:0] fill_hold_q;
   logic [FILL_W-1:0]      wmark_q;
   logic [7:0]             queue_byte;
   logic                   queue_empty;
   logic                   full_now;
   logic                   full_prev_q;
   logic                   wm_now;
   logic                   wm_prev_q;
   logic                   pop;

   // read path
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;

   // read strobe decode; strobes are single cycle and never overlap
   // not gated by clk_en: every user sits in an enabled branch
   always_comb begin
      rd_feat     = reg_req.rd && (reg_req.addr == ADDR_FEATURE_FLAGS);
      rd_data     = reg_req.rd && (reg_req.addr == ADDR_DATA_FLAGS);
      rd_step0    = reg_req.rd && (reg_req.addr == ADDR_STEP_BYTE0);
      rd_fill_low = reg_req.rd && (reg_req.addr == ADDR_FILL_LOW);
      rd_port     = reg_req.rd && (reg_req.addr == ADDR_QUEUE_PORT);
   end

   // write strobe decode; only the watermark bytes take writes
   // writes to read-only or unmapped addresses fall through
   always_comb begin
      wr_wm_low   = reg_req.wr && (reg_req.addr == ADDR_WMARK_LOW);
      wr_wm_high  = reg_req.wr && (reg_req.addr == ADDR_WMARK_HIGH);
   end

   // the queue itself; a read of the port drains exactly one byte
   // an empty queue ignores the pop, the port reads the empty code
   assign pop = rd_port; // [R10]

   // its count is the fill level that software sees
   byte_queue #(
      .DEPTH  (DEPTH),
      .DATA_W (8),
      .CNT_W  (FILL_W)
   ) u_queue (
      .clk      (clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .wr_valid (queue_wr_valid),
      .wr_ready (queue_wr_ready),
      .wr_data  (queue_wr_data),
      .rd_en    (pop),
      .rd_data  (queue_byte),
      .count    (fill), // [R7]
      .full     (full_now),
      .empty    (queue_empty)
   );

   // level conditions; a zero watermark disables that event
   // combinational, so the producer sees full in the same cycle
   assign wm_now      = (wmark_q != '0) && (fill >= wmark_q);
   assign queue_full  = full_now;
   assign queue_wmark = wm_now;

   // watermark level is software writable, upper bits of high byte dropped
   // one flop set for both bytes, so it keeps a single driver
   always_ff @(posedge clk) begin
      if (rst) begin
         wmark_q <= WMARK_RESET;
      end else if (clk_en) begin
         if (wr_wm_low) begin
            wmark_q[7:0] <= reg_req.wdata;
         end
         if (wr_wm_high) begin
            wmark_q[FILL_W-1:8] <= reg_req.wdata[FILL_HIGH_W-1:0];
         end
      end
   end

   // previous full level, so only the entering edge raises a flag
   // a queue that stays full raises the flag once
   always_ff @(posedge clk) begin
      if (rst) begin
         full_prev_q <= 1'b0;
      end else if (clk_en) begin
         full_prev_q <= full_now;
      end
   end

   // previous watermark level, same entering edge scheme
   always_ff @(posedge clk) begin
      if (rst) begin
         wm_prev_q <= 1'b0;
      end else if (clk_en) begin
         wm_prev_q <= wm_now;
      end
   end

   // sample the step count; data outputs come from flops
   // one cycle behind the engine, taken every enabled cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         step_q <= '0;
      end else if (clk_en) begin
         step_q <= step_count;
      end
   end

   // sample the temperature code
   // passed on untouched; zero stands for 23 C
   always_ff @(posedge clk) begin
      if (rst) begin
         temp_q <= '0;
      end else if (clk_en) begin
         temp_q <= die_temp; // [R6]
      end
   end

   // activity classification sample
   // reset to still, so the field reads the still code until the first sample
   always_ff @(posedge clk) begin
      if (rst) begin
         class_q <= CLASS_STILL;
      end else if (clk_en) begin
         class_q <= motion_class; // [R12]
      end
   end

   // marks that one sample has been taken since reset
   always_ff @(posedge clk) begin
      if (rst) begin
         class_seen_q <= 1'b0;
      end else if (clk_en) begin
         class_seen_q <= 1'b1;
      end
   end

   // first sample after reset is not counted as a change
   // trade-off: a class held for one cycle still raises the flag
   assign class_change = class_seen_q && (motion_class != class_q);

   // feature event sources mapped onto their bit positions
   // reserved positions 4 and 0 keep the zero of the default
   always_comb begin
      feat_set                    = 8'h00;
      feat_set[FEAT_ERROR_BIT]    = feat_events.error;         // [R2]
      feat_set[FEAT_MOTION_BIT]   = feat_events.any_no_motion; // [R2]
      feat_set[FEAT_WAKEUP_BIT]   = feat_events.wakeup;        // [R2]
      feat_set[FEAT_TILT_BIT]     = feat_events.wrist_tilt;    // [R2]
      feat_set[FEAT_ACTIVITY_BIT] = class_change;              // [R2]
      feat_set[FEAT_STEP_BIT]     = feat_events.step;          // [R2]
   end

   // data and queue event sources mapped onto their bit positions
   // queue events fire on entry only, the level is not stored
   always_comb begin
      data_set                      = 8'h00;
      data_set[DATA_ACC_RDY_BIT]    = data_events.acc_ready;   // [R4]
      data_set[DATA_AUX_RDY_BIT]    = data_events.aux_ready;   // [R4]
      data_set[DATA_QUEUE_WM_BIT]   = wm_now & ~wm_prev_q;     // [R4]
      data_set[DATA_QUEUE_FULL_BIT] = full_now & ~full_prev_q; // [R4]
   end

   // clear on read, but an event in the clearing cycle survives
   // otherwise a pulse landing in the read cycle would be lost
   always_comb begin
      feat_flags_d = (rd_feat ? 8'h00 : feat_flags_q) | feat_set; // [R1]
      data_flags_d = (rd_data ? 8'h00 : data_flags_q) | data_set; // [R3]
   end

   // sticky feature flags
   // cleared only by a read of this byte or by reset
   always_ff @(posedge clk) begin
      if (rst) begin
         feat_flags_q <= FLAGS_RESET;
      end else if (clk_en) begin
         feat_flags_q <= feat_flags_d;
      end
   end

   // sticky data and queue flags
   // cleared only by a read of this byte or by reset
   always_ff @(posedge clk) begin
      if (rst) begin
         data_flags_q <= FLAGS_RESET;
      end else if (clk_en) begin
         data_flags_q <= data_flags_d;
      end
   end

   // a low byte read freezes the upper bytes, so a burst reads coherently
   // limitation: bytes 1..3 stay stale until byte 0 is read again
   always_ff @(posedge clk) begin
      if (rst) begin
         step_hold_q <= '0;
      end else if (clk_en) begin
         if (rd_step0) begin
            step_hold_q <= step_q; // [R5]
         end
      end
   end

   // the fill low byte read freezes bits 13:8 the same way
   always_ff @(posedge clk) begin
      if (rst) begin
         fill_hold_q <= '0;
      end else if (clk_en) begin
         if (rd_fill_low) begin
            fill_hold_q <= fill[FILL_W-1:8]; // [R8]
         end
      end
   end

   // read multiplexer; reserved bits and unmapped addresses read zero
   // watermark bytes read back so software can verify a write
   always_comb begin
      rd_mux = UNMAPPED_RD;
      unique case (reg_req.addr)
         ADDR_FEATURE_FLAGS: begin
            rd_mux = feat_flags_q; // [R2]
         end
         ADDR_DATA_FLAGS: begin
            rd_mux = data_flags_q; // [R4]
         end
         ADDR_STEP_BYTE0: begin
            rd_mux = step_q[7:0]; // [R5]
         end
         ADDR_STEP_BYTE1: begin
            rd_mux = step_hold_q[15:8]; // [R5]
         end
         ADDR_STEP_BYTE2: begin
            rd_mux = step_hold_q[23:16]; // [R5]
         end
         ADDR_STEP_BYTE3: begin
            rd_mux = step_hold_q[31:24]; // [R5]
         end
         ADDR_DIE_TEMP: begin
            rd_mux = temp_q; // [R6]
         end
         ADDR_FILL_LOW: begin
            rd_mux = fill[7:0]; // [R8]
         end
         ADDR_FILL_HIGH: begin
            rd_mux = {2'b00, fill_hold_q}; // [R8]
         end
         ADDR_QUEUE_PORT: begin
            rd_mux = queue_empty ? EMPTY_RD : queue_byte; // [R9]
         end
         ADDR_MOTION_CLASS: begin
            rd_mux = {6'b000000, class_q}; // [R11]
         end
         ADDR_WMARK_LOW: begin
            rd_mux = wmark_q[7:0];
         end
         ADDR_WMARK_HIGH: begin
            rd_mux = {2'b00, wmark_q[FILL_W-1:8]};
         end
         default: begin
            rd_mux = UNMAPPED_RD;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   // zero between answers keeps stale values off an idle bus
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= BYTE_RESET;
      end else if (clk_en) begin
         rdata_q <= reg_req.rd ? rd_mux : BYTE_RESET;
      end
   end

   // registered read data straight to the port
   assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ==== verif/status_readout_properties.sv ====
// port checker of the status readout register bank
`timescale 1ns/1ps
`default_nettype none
module status_readout_checker
   import status_readout_pkg::*;
#(
   parameter int DEPTH = 1024
) (
   // clock and control
   input wire logic                                   clk,
   input wire logic                                   rst,
   input wire logic                                   clk_en,
   // register port
   input wire status_readout_pkg::reg_req_t           reg_req,
   input wire logic [7:0]                             reg_rdata,
   // engine inputs
   input wire status_readout_pkg::feature_events_t    feat_events,
   input wire logic [status_readout_pkg::STEP_W-1:0]  step_count,
   input wire logic signed [7:0]                      die_temp,
   input wire status_readout_pkg::motion_class_t      motion_class,
   // queue levels
   input wire logic                                   queue_wr_ready,
   input wire logic                                   queue_full
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a read strobe taken at this edge
   wire logic rd_on = clk_en && reg_req.rd;

   // read data only in the cycle after a read
   chk_rdata_idle: assert property (
      clk_en && !reg_req.rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   // a second read with no new cause sees nothing
   chk_feat_clear: assert property (
      rd_on && reg_req.addr == ADDR_FEATURE_FLAGS && feat_events == '0
      && $stable(motion_class) ##1 rd_on
      && reg_req.addr == ADDR_FEATURE_FLAGS && $stable(motion_class)
      |=> reg_rdata == 8'h00)
      else $error("feature flags survive a read");
   chk_feat_spare: assert property (
      rd_on && reg_req.addr == ADDR_FEATURE_FLAGS
      |=> (reg_rdata & 8'h11) == 8'h00)
      else $error("feature flag spare bits set");
   chk_data_spare: assert property (
      rd_on && reg_req.addr == ADDR_DATA_FLAGS
      |=> (reg_rdata & 8'h5C) == 8'h00)
      else $error("data flag spare bits set");
   chk_fill_spare: assert property (
      rd_on && reg_req.addr == ADDR_FILL_HIGH |=> reg_rdata[7:6] == 2'h0)
      else $error("fill high spare bits set");
   // live values seen through a one-cycle sample
   chk_class_read: assert property (
      clk_en ##1 rd_on && reg_req.addr == ADDR_MOTION_CLASS
      && $stable(motion_class) |=> reg_rdata == {6'h00, $past(motion_class)})
      else $error("class byte wrong");
   chk_temp_read: assert property (
      clk_en ##1 rd_on && reg_req.addr == ADDR_DIE_TEMP
      && $stable(die_temp) |=> reg_rdata == $past(die_temp))
      else $error("temperature byte wrong");
   chk_step_low: assert property (
      clk_en ##1 rd_on && reg_req.addr == ADDR_STEP_BYTE0
      && $stable(step_count) |=> reg_rdata == $past(step_count[7:0]))
      else $error("step low byte wrong");
   chk_ready_full: assert property (queue_wr_ready == !queue_full)
      else $error("push ready disagrees with full");

   // main scenarios reached
   cov_feat_read: cover property (rd_on && reg_req.addr == ADDR_FEATURE_FLAGS);
   cov_full: cover property (queue_full);
   cov_pop: cover property (rd_on && reg_req.addr == ADDR_QUEUE_PORT);
endmodule

bind status_readout_register_bank status_readout_checker #(.DEPTH(DEPTH))
   chk_i (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .feat_events(feat_events),
   .step_count(step_count), .die_temp(die_temp),
   .motion_class(motion_class), .queue_wr_ready(queue_wr_ready),
   .queue_full(queue_full));
`default_nettype wire

// ==== verif/host_model.sv ====
// host register master model for the status readout bank
`timescale 1ns/1ps
`default_nettype none
module host_model
   import status_readout_pkg::*;
(
   // clock
   input  wire logic                         clk,
   // register port
   output var status_readout_pkg::reg_req_t  reg_req,
   input  wire logic [7:0]                   reg_rdata
);
   // bus idle at time zero
   initial reg_req = '0;
   // one-cycle write; address and data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   // one-cycle read, data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      reg_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      @(negedge clk);
      d = reg_rdata;
   endtask
   // two reads back to back, no idle cycle between the strobes
   task automatic rd2(input logic [7:0] a, output logic [7:0] d0,
                      output logic [7:0] d1);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      @(negedge clk);
      d0 = reg_rdata;
      @(posedge clk);
      reg_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      @(negedge clk);
      d1 = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ==== verif/status_readout_register_bank_tb.sv ====
// self-checking bench of the status readout register bank
`timescale 1ns/1ps
`default_nettype none
module status_readout_register_bank_tb;
   import status_readout_pkg::*;
   localparam int TB_DEPTH = 8; // small depth reaches full quickly
   logic                 clk;
   logic                 rst;
   logic                 clk_en;
   reg_req_t             reg_req;
   logic [7:0]           reg_rdata;
   feature_events_t      feat_events;
   data_events_t         data_events;
   logic [STEP_W-1:0]    step_count;
   logic signed [7:0]    die_temp;
   motion_class_t        motion_class;
   logic                 queue_wr_valid;
   logic                 queue_wr_ready;
   logic [7:0]           queue_wr_data;
   logic                 queue_full;
   logic                 queue_wmark;
   int                   fail_count = 0;
   int                   tests_run = 0;
   logic [7:0]           got0;
   logic [7:0]           got1;
   // address and expected byte; step byte 0 first to freeze the rest
   logic [15:0]          rows [11] = '{16'h1EEF, 16'h1FCD, 16'h20AB,
      16'h2189, 16'h22FB, 16'h2400, 16'h2500, 16'h2600, 16'h2702,
      16'h2300, 16'h1D00};

   status_readout_register_bank #(.DEPTH(TB_DEPTH)) DUT (.clk(clk),
      .rst(rst), .clk_en(clk_en), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .feat_events(feat_events),
      .data_events(data_events), .step_count(step_count),
      .die_temp(die_temp), .motion_class(motion_class),
      .queue_wr_valid(queue_wr_valid), .queue_wr_ready(queue_wr_ready),
      .queue_wr_data(queue_wr_data), .queue_full(queue_full),
      .queue_wmark(queue_wmark));
   host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // compare and count
   task automatic check(input string n, input logic [7:0] e,
                        input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic rdchk(input string n, input logic [7:0] a,
                        input logic [7:0] e);
      logic [7:0] g;
      host.rd(a, g);
      check(n, e, g);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard, far beyond the 133 cycles the tests need
   initial begin
      #20000;
      fail_count++;
      complete_run();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      feat_events = '0;
      data_events = '0;
      step_count = 32'h89ABCDEF;
      die_temp = 8'shFB;
      motion_class = CLASS_RUNNING;
      queue_wr_valid = 1'b0;
      queue_wr_data = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         rdchk("reg_row", rows[i][15:8], rows[i][7:0]);
      end
      $display("register table test done");
      for (int c = 0; c < 4; c++) begin
         @(posedge clk);
         motion_class <= motion_class_t'(c);
         rdchk("class", ADDR_MOTION_CLASS, 8'(c));
      end
      rdchk("feat_act", ADDR_FEATURE_FLAGS, 8'h04);
      rdchk("feat_empty", ADDR_FEATURE_FLAGS, 8'h00);
      @(posedge clk);
      feat_events <= '1;
      data_events <= '1;
      @(posedge clk);
      feat_events <= '0;
      data_events <= '0;
      host.rd2(ADDR_FEATURE_FLAGS, got0, got1);
      check("feat_set", 8'hEA, got0);
      check("feat_clr", 8'h00, got1);
      rdchk("data_set", ADDR_DATA_FLAGS, 8'hA0);
      rdchk("data_clr", ADDR_DATA_FLAGS, 8'h00);
      host.wr(ADDR_DIE_TEMP, 8'h11);
      rdchk("temp_ro", ADDR_DIE_TEMP, 8'hFB);
      host.wr(ADDR_WMARK_LOW, 8'h03);
      rdchk("wmark", ADDR_WMARK_LOW, 8'h03);
      $display("flag test done");
      // one push too many: the last byte must be dropped
      @(posedge clk);
      for (int i = 0; i < TB_DEPTH + 1; i++) begin
         queue_wr_valid <= 1'b1;
         queue_wr_data <= 8'h10 + 8'(i);
         @(posedge clk);
      end
      queue_wr_valid <= 1'b0;
      @(negedge clk);
      check("full", 8'h01, {7'h00, queue_full});
      check("ready", 8'h00, {7'h00, queue_wr_ready});
      check("wmark_lvl", 8'h01, {7'h00, queue_wmark});
      rdchk("fill_lo", ADDR_FILL_LOW, 8'(TB_DEPTH));
      rdchk("fill_hi", ADDR_FILL_HIGH, 8'h00);
      rdchk("queue_evt", ADDR_DATA_FLAGS, 8'h03);
      for (int i = 0; i < TB_DEPTH; i++) begin
         rdchk("pop", ADDR_QUEUE_PORT, 8'h10 + 8'(i));
         rdchk("fill", ADDR_FILL_LOW, 8'(TB_DEPTH - 1 - i));
      end
      rdchk("pop_empty", ADDR_QUEUE_PORT, 8'h00);
      $display("queue test done");
      // a frozen cycle swallows an event pulse
      @(posedge clk);
      clk_en <= 1'b0;
      feat_events <= '1;
      @(posedge clk);
      clk_en <= 1'b1;
      feat_events <= '0;
      rdchk("frozen", ADDR_FEATURE_FLAGS, 8'h00);
      $display("enable test done");
      // reset in mid-run drops pending flags and the watermark
      @(posedge clk);
      feat_events <= '1;
      @(posedge clk);
      feat_events <= '0;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdchk("rst_flags", ADDR_FEATURE_FLAGS, 8'h00);
      rdchk("rst_wmark", ADDR_WMARK_LOW, 8'h00);
      $display("reset test done");
      complete_run();
   end
endmodule
`default_nettype wire
